// ===== hdl/swdt_top.sv
// System watchdog timer: loadable down counter with system reset output
// Contract
// - Nonzero load starts countdown per tick.
// - Keyboard activity reloads the running count.
// - Expiry asserts whole-system reset.
// - Tick is one second or one minute.
// - Count and one control register held.
// - Zero load disables watchdog.
`timescale 1ns/1ps
`default_nettype none
module swdt_top #(
    parameter int unsigned SEC_CYCLES = swdt_pkg::SEC_CYCLES,
    parameter int unsigned MIN_SECS = swdt_pkg::MIN_TIME_S
) (
    input wire logic clk_sys,                 // System clock, 200 MHz
    input wire logic sys_rst,                 // Synchronous reset, high
    input wire swdt_pkg::swdt_load_t ld,      // Timeout load request
    input wire logic kbd_activity,            // Keyboard activity pulse
    output logic running,                     // Countdown is active
    output logic [7:0] count_now,             // Current remaining count
    output logic sys_reset_out                // One-cycle system reset
);
    // ---------------------------------------------------------------
    // Held configuration
    // ---------------------------------------------------------------
    logic [7:0] reload_reg;
    logic unit_min_reg;
    logic [7:0] cnt_reg;
    logic run_reg;
    logic [31:0] pre_reg;
    logic [31:0] sec_reg;
    logic tick;
    logic [31:0] pre_top;
    logic expire;

    assign pre_top = SEC_CYCLES - 1;
    assign tick = run_reg && (pre_reg == pre_top)
        && (!unit_min_reg || sec_reg == (MIN_SECS - 1));
    assign expire = tick && (cnt_reg == swdt_pkg::CNT_ONE)
        && !kbd_activity && !ld.load;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            reload_reg <= swdt_pkg::CNT_RESET_VAL;
            unit_min_reg <= 1'b0;
        end
        else if (ld.load)
        begin
            reload_reg <= ld.count;
            unit_min_reg <= ld.unit_minute;
        end
    end

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || ld.load || kbd_activity || !run_reg)
        begin
            pre_reg <= '0;
            sec_reg <= '0;
        end
        else if (pre_reg == pre_top)
        begin
            pre_reg <= '0;
            if (!unit_min_reg || sec_reg == (MIN_SECS - 1))
                sec_reg <= '0;
            else
                sec_reg <= sec_reg + 32'd1;
        end
        else
            pre_reg <= pre_reg + 32'd1;
    end

    // ---------------------------------------------------------------
    // Down counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_reg <= swdt_pkg::CNT_RESET_VAL;
            run_reg <= 1'b0;
        end
        else if (ld.load)
        begin
            cnt_reg <= ld.count;
            run_reg <= (ld.count != swdt_pkg::CNT_ZERO);
        end
        else if (kbd_activity && run_reg)
            cnt_reg <= reload_reg;
        else if (tick)
        begin
            cnt_reg <= cnt_reg - swdt_pkg::CNT_ONE;
            if (cnt_reg == swdt_pkg::CNT_ONE)
                run_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sys_reset_out <= 1'b0;
        else
            sys_reset_out <= expire;
    end

    assign running = run_reg;
    assign count_now = cnt_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Cycles since the last tick or restart, counted apart from the prescaler
    logic [63:0] gap_reg;
    logic [63:0] gap_last;

    assign gap_last = unit_min_reg
        ? 64'(SEC_CYCLES) * 64'(MIN_SECS) - 64'd1
        : 64'(SEC_CYCLES) - 64'd1;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || ld.load || kbd_activity || !run_reg || tick)
            gap_reg <= '0;
        else
            gap_reg <= gap_reg + 64'd1;
    end

    a_reset_values: assert property (
        @(posedge clk_sys)
        sys_rst |=> !running && count_now == swdt_pkg::CNT_RESET_VAL
            && !sys_reset_out)
        else $error("reset left watchdog active");

    a_zero_disables: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ld.load && ld.count == 8'h00 |=> !running)
        else $error("zero load left watchdog running");

    a_nonzero_starts: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ld.load && ld.count != 8'h00
            |=> running && count_now == $past(ld.count))
        else $error("nonzero load did not start countdown");

    a_load_wins: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ld.load && kbd_activity |=> count_now == $past(ld.count))
        else $error("keyboard activity overrode a load");

    a_kbd_reload: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        kbd_activity && running && !ld.load |=> count_now == reload_reg)
        else $error("keyboard activity did not reload");

    a_kbd_idle: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        kbd_activity && !running && !ld.load
            |=> !running && count_now == $past(count_now))
        else $error("keyboard activity woke a stopped watchdog");

    a_reload_take: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ld.load |=> reload_reg == $past(ld.count))
        else $error("load value not held for restarts");

    a_reload_hold: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !ld.load |=> reload_reg == $past(reload_reg))
        else $error("held load value changed without a load");

    a_tick_step: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        tick && !ld.load && !kbd_activity
            |=> count_now == $past(count_now) - 8'h01)
        else $error("tick did not decrement");

    a_count_hold: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        running && !ld.load && !kbd_activity && gap_reg != gap_last
            |=> count_now == $past(count_now))
        else $error("count moved between ticks");

    a_sec_tick: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        tick && !unit_min_reg |-> gap_reg == gap_last)
        else $error("second tick off its period");

    a_min_tick: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        tick && unit_min_reg |-> gap_reg == gap_last)
        else $error("minute tick off its period");

    a_tick_due: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        running && gap_reg == gap_last |-> tick)
        else $error("tick missing at end of period");

    a_expire_reset: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        sys_reset_out |-> $past(count_now) == 8'h01 && !running)
        else $error("reset without expiry");

    a_expiry_due: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        running && count_now == swdt_pkg::CNT_ONE && gap_reg == gap_last
            && !kbd_activity && !ld.load |=> sys_reset_out)
        else $error("expiry did not reset the system");

    a_reset_pulse: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        sys_reset_out |=> !sys_reset_out)
        else $error("system reset longer than one cycle");

    a_idle_no_reset: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !running && !$past(running) |-> !sys_reset_out)
        else $error("reset while disabled");
endmodule : swdt_top
`default_nettype wire

// ===== common/swdt_pkg.sv
// Shared constants and carrier types for the system watchdog timer
`default_nettype none
package swdt_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SEC_TIME_S = 1;
    localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_TIME_S;
    localparam int unsigned MIN_TIME_S = 60;
    // ---------------------------------------------------------------
    // Counter layout
    // ---------------------------------------------------------------
    localparam int unsigned CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_RESET_VAL = 8'h00;
    // Carrier for a software load of the timeout count
    typedef struct packed {
        logic load;           // One-cycle load strobe
        logic unit_minute;    // 1: one-minute ticks, 0: one-second ticks
        logic [7:0] count;    // Timeout in selected units
    } swdt_load_t;
endpackage : swdt_pkg
`default_nettype wire

// ===== dv/swdt_top_test.sv
// Self-checking bench for the system watchdog timer
`timescale 1ns/1ps
`default_nettype none
module swdt_top_test;
    localparam int SC = 10;
    localparam int MS = 3;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    swdt_pkg::swdt_load_t ld = '0;
    logic kbd_activity = 1'b0;
    logic running;
    logic [7:0] count_now;
    logic sys_reset_out;
    int fail_count = 0;
    int checks = 0;
    swdt_top #(.SEC_CYCLES(SC), .MIN_SECS(MS)) swdt_top_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ld(ld),
        .kbd_activity(kbd_activity), .running(running),
        .count_now(count_now), .sys_reset_out(sys_reset_out));
    always #2.5 clk_sys = ~clk_sys;
    function automatic int expiry(input int n, input bit m);
        return n * SC * (m ? MS : 1);
    endfunction : expiry
    // Unit choice software makes for a request of s seconds
    function automatic logic [8:0] to_units(input int s);
        if (s <= 32'hff)
            return {1'b0, 8'(s)};
        else
            return {1'b1, 8'(s / swdt_pkg::MIN_TIME_S)};
    endfunction : to_units
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic load(input logic [7:0] n, input logic m);
        @(negedge clk_sys);
        ld = '{load: 1'b1, unit_minute: m, count: n};
        @(negedge clk_sys);
        ld.load = 1'b0;
        check(running, 8'(n != 8'h00));
        check(count_now, n);
    endtask : load
    // Load n units, optionally press a key at cycle kb, time the expiry
    task automatic run(input logic [7:0] n, input logic m, input int kb);
        int c;
        int e;
        e = expiry(n, m) + 1 + ((kb != 0) ? kb : 0);
        load(n, m);
        c = 1;
        while (c < e + 4 && sys_reset_out !== 1'b1)
        begin
            kbd_activity = (c == kb);
            @(negedge clk_sys);
            c++;
            if (kb != 0 && c == kb + 1) check(count_now, n);
        end
        kbd_activity = 1'b0;
        check(8'(c == e), 8'h01);
        @(negedge clk_sys);
        check(running, 8'h00);
        check(sys_reset_out, 8'h00);
        $display("test done n=%0d minute=%0d key=%0d", n, m, kb);
    endtask : run
    // Stopped watchdog must stay quiet, keyboard activity or not
    task automatic quiet(input int k);
        repeat (k)
        begin
            kbd_activity = 1'($urandom_range(0, 1));
            @(negedge clk_sys);
            check(sys_reset_out, 8'h00);
            check(running, 8'h00);
        end
        kbd_activity = 1'b0;
    endtask : quiet
    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        int s;
        int kb;
        logic [8:0] u;
        void'($urandom(32'h6bba1856));
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        check(running, 8'h00);
        check(count_now, 8'h00);
        check(sys_reset_out, 8'h00);
        $display("test done reset values");
        run(8'h02, 1'b0, 0);
        run(8'h01, 1'b1, 0);
        run(8'h03, 1'b0, 27);
        run(8'hff, 1'b0, 0);
        run(8'hff, 1'b1, 0);
        load(8'h03, 1'b0);
        load(8'h00, 1'b0);
        quiet(5 * SC);
        $display("test done zero load");
        @(negedge clk_sys);
        kbd_activity = 1'b1;
        load(8'h04, 1'b0);
        kbd_activity = 1'b0;
        repeat (SC + 3) @(negedge clk_sys);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        check(running, 8'h00);
        check(count_now, 8'h00);
        sys_rst = 1'b0;
        quiet(5 * SC);
        $display("test done mid-run reset");
        repeat (6)
        begin
            if ($urandom_range(0, 1))
                s = $urandom_range(2, 5);
            else
                s = swdt_pkg::MIN_TIME_S * $urandom_range(5, 8);
            u = to_units(s);
            kb = $urandom_range(0, 1) ? expiry(u[7:0], u[8]) - 3 : 0;
            run(u[7:0], u[8], kb);
        end
        summarize();
    end
    initial
    begin
        // Roughly two and a half times the expected length of all tests
        #150us;
        fail_count++;
        summarize();
    end
endmodule : swdt_top_test
`default_nettype wire
